/* File: ppo_port_b.sv */
// ppo_port_b.sv: port B pin override logic with its output, direction, pin and control registers
// assumes: Avalon-MM master on clock; peripheral override/compare signals arrive synchronous to clock
// Notes on behaviour
// [R1] deep-sleep clamp forces digital input low
// [R2] external interrupt enable exempts pin from clamp
// [R3] clamp release edge sets interrupt flag
// [R4] pull-ups switched off during reset
// [R5] pull-up from override or 010 combination
// [R6] pull-up override value wins when enabled
// [R7] driver enable from override or direction bit
// [R8] direction override value wins when enabled
// [R9] driven level from override or output bit
// [R10] value override ignores output bit
// [R11] toggle override inverts output bit
// [R12] input enable from override or sleep state
// [R13] input enable override value wins
// [R14] peripherals synchronise the raw input themselves
// [R15] analog path goes straight to pad
// [R16] overrides produced by owning peripherals
// [R17] timer compare outputs on bits 7..4
// [R18] SPI and programming pins on bits 3..0
// [R19] every bit is a pin-change source
// [R20] default direction/output pin behaviour
// [R21] writing one to pin register toggles output
// [R22] overrides deasserted after reset
`timescale 1ns/1ns
`include "ppo_defs.svh"
module ppo_port_b (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic [7:0] padIn,
  output logic [7:0] padOe,
  output logic [7:0] padOut,
  output logic [7:0] pullupOn,
  output logic [7:0] rawDigitalIn,
  output logic [7:0] pinChangeIrqSrc,
  input wire logic [7:0] extIrqEnable,
  input wire logic [7:0] toggleOvrEn,
  input wire logic timer0CmpAOut,
  input wire logic timer1CmpAOut,
  input wire logic timer1CmpBOut,
  input wire logic timer1CmpCOut,
  input wire logic timer2CmpAOut,
  input wire logic spiMasterOut,
  input wire logic spiSlaveOut,
  input wire logic spiSckOut,
  output logic spiMisoIn,
  output logic spiMosiIn,
  output logic spiSckIn,
  output logic spiSlaveSelIn,
  output logic progDataIn,
  input wire logic progDataOut,
  input wire logic progEnable
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ppo_pkg::ppo_bus_e bus;
    logic [31:0] rdata;
    logic [7:0] outBits;
    logic [7:0] dirBits;
    logic [7:0] pinSync;
    logic [7:0] ctrl;
    logic [7:0] alt;
    logic inResetN;
    logic [7:0] padOe;
    logic [7:0] padOut;
    logic [7:0] pullupOn;
    logic [7:0] rawIn;
    logic [7:0] clampEdge;
    logic [7:0] rawPrev;
    logic spiMiso;
    logic spiMosi;
    logic spiSck;
    logic spiSs;
  } ppo_state_s;
  ppo_state_s st_r;
  ppo_state_s st_nxt;
  ppo_pkg::ppo_ovr_s ovr [8];
  logic [7:0] cellOe;
  logic [7:0] cellOut;
  logic [7:0] cellPu;
  logic [7:0] cellDi;
  logic spe;
  logic mstr;
  logic pcie;
  logic global_pullup_disable;
  logic sleepClamp;
  logic [7:0] cmpEn;
  logic [7:0] cmpVal;
  assign spe = st_r.alt[`PPO_ALT_SPE] | progEnable;
  assign mstr = st_r.alt[`PPO_ALT_MSTR];
  assign pcie = st_r.alt[`PPO_ALT_PCIE];
  assign global_pullup_disable = st_r.ctrl[`PPO_CTRL_PUD];
  assign sleepClamp = st_r.ctrl[`PPO_CTRL_SLEEP];
  // ****************************************
  // alternate-function override map
  // ****************************************
  always_comb begin
    cmpEn = 8'h00;
    cmpVal = 8'h00;
    cmpEn[7] = st_r.alt[`PPO_ALT_TIMER0_CMP_A_OUT] | st_r.alt[`PPO_ALT_TIMER1_CMP_C_OUT]; // R17
    cmpVal[7] = (st_r.alt[`PPO_ALT_TIMER0_CMP_A_OUT] & timer0CmpAOut) | (st_r.alt[`PPO_ALT_TIMER1_CMP_C_OUT] & timer1CmpCOut); // R17
    cmpEn[6] = st_r.alt[`PPO_ALT_TIMER1_CMP_B_OUT]; // R17
    cmpVal[6] = timer1CmpBOut;
    cmpEn[5] = st_r.alt[`PPO_ALT_TIMER1_CMP_A_OUT]; // R17
    cmpVal[5] = timer1CmpAOut;
    cmpEn[4] = st_r.alt[`PPO_ALT_TIMER2_CMP_A_OUT]; // R17
    cmpVal[4] = timer2CmpAOut;
    // spi/programming roles; programming mode drives data out as a slave would
    cmpEn[3] = spe & !mstr; // R18
    cmpVal[3] = progEnable ? progDataOut : spiSlaveOut; // R18
    cmpEn[2] = spe & mstr; // R18
    cmpVal[2] = spiMasterOut;
    cmpEn[1] = spe & mstr; // R18
    cmpVal[1] = spiSckOut;
  end
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      logic spiForceIn;
      // each of bits 3..0 is forced to input in the spi role that receives on it; bits 7..4 never are
      assign spiForceIn = (gi == 3) ? (spe & mstr) : (gi < 3) ? (spe & !mstr) : 1'b0; // R18
      always_comb begin
        ovr[gi].puOvrEn = spiForceIn;
        ovr[gi].puOvrVal = st_r.outBits[gi] & !global_pullup_disable;
        ovr[gi].dirOvrEn = spiForceIn;
        ovr[gi].dirOvrVal = 1'b0;
        ovr[gi].valOvrEn = cmpEn[gi];
        ovr[gi].valOvrVal = cmpVal[gi];
        ovr[gi].inEnOvrEn = (pcie | extIrqEnable[gi]) & st_r.inResetN; // R2 R19 R22
        ovr[gi].inEnOvrVal = 1'b1;
      end
      ppo_pin_cell u_cell (
        .dirBit(st_r.dirBits[gi]),
        .outBit(st_r.outBits[gi]),
        .globalPullupDisable(global_pullup_disable),
        .sleepClamp(sleepClamp),
        .inResetN(st_r.inResetN),
        .ovr(ovr[gi]),
        .padIn(padIn[gi]),
        .padOe(cellOe[gi]),
        .padOut(cellOut[gi]),
        .pullupOn(cellPu[gi]),
        .rawDigitalIn(cellDi[gi])
      );
    end
  endgenerate
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] wbyte;
    logic hit;
    wbyte = avsWritedata[7:0];
    hit = avsWrite & avsByteenable[0] & (st_r.bus == ppo_pkg::PPO_BUS_IDLE);
    st_nxt = st_r;
    st_nxt.inResetN = 1'b1;
    // toggle overrides invert the output bit every cycle they stand
    st_nxt.outBits = st_r.outBits ^ toggleOvrEn; // R11
    if (hit) begin
      case (avsAddress)
        `PPO_OFS_OUT: st_nxt.outBits = wbyte ^ toggleOvrEn;
        `PPO_OFS_DIR: st_nxt.dirBits = wbyte;
        `PPO_OFS_PIN: st_nxt.outBits = st_r.outBits ^ wbyte ^ toggleOvrEn; // R21
        `PPO_OFS_CTRL: st_nxt.ctrl = wbyte & 8'h03;
        `PPO_OFS_ALT: st_nxt.alt = wbyte;
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    // one wait state: answer in the cycle after the request is seen
    case (st_r.bus)
      ppo_pkg::PPO_BUS_IDLE: begin
        if (avsRead | avsWrite) begin
          st_nxt.bus = ppo_pkg::PPO_BUS_ACK;
        end
        case (avsAddress)
          `PPO_OFS_OUT: st_nxt.rdata = {24'h00_0000, st_r.outBits};
          `PPO_OFS_DIR: st_nxt.rdata = {24'h00_0000, st_r.dirBits};
          `PPO_OFS_PIN: st_nxt.rdata = {24'h00_0000, st_r.pinSync};
          `PPO_OFS_CTRL: st_nxt.rdata = {24'h00_0000, st_r.ctrl};
          `PPO_OFS_PAD: st_nxt.rdata = {24'h00_0000, st_r.rawIn};
          `PPO_OFS_ALT: st_nxt.rdata = {24'h00_0000, st_r.alt};
          default: st_nxt.rdata = `PPO_BAD_READ;
        endcase
      end
      ppo_pkg::PPO_BUS_ACK: st_nxt.bus = ppo_pkg::PPO_BUS_IDLE;
      default: st_nxt.bus = ppo_pkg::PPO_BUS_IDLE;
    endcase
    // pin register: second stage behind the clamped raw input
    st_nxt.pinSync = st_r.rawIn;
    st_nxt.rawIn = cellDi;
    st_nxt.rawPrev = st_r.rawIn;
    // high pin released from clamp shows as a rising edge to interrupt logic
    st_nxt.clampEdge = st_r.rawIn & ~st_r.rawPrev; // R3
    st_nxt.padOe = cellOe;
    st_nxt.padOut = cellOut;
    st_nxt.pullupOn = cellPu;
    st_nxt.spiMiso = cellDi[3];
    st_nxt.spiMosi = cellDi[2];
    st_nxt.spiSck = cellDi[1];
    st_nxt.spiSs = cellDi[0];
    if (rst) begin
      st_nxt.bus = ppo_pkg::PPO_BUS_IDLE;
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.outBits = `PPO_RST_BYTE;
      st_nxt.dirBits = `PPO_RST_BYTE; // R20
      st_nxt.ctrl = `PPO_RST_BYTE;
      st_nxt.alt = `PPO_RST_BYTE; // R22
      st_nxt.inResetN = 1'b0; // R4
      st_nxt.padOe = 8'h00;
      st_nxt.pullupOn = 8'h00; // R4
    end
  end
  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end
  // ****************************************
  // outputs
  // ****************************************
  assign avsReaddata = st_r.rdata;
  assign avsWaitrequest = (st_r.bus == ppo_pkg::PPO_BUS_IDLE);
  assign padOe = st_r.padOe;
  assign padOut = st_r.padOut;
  assign pullupOn = st_r.pullupOn;
  // registered raw input; peripherals add their own two synchroniser stages
  assign rawDigitalIn = st_r.rawIn; // R14 R16
  assign pinChangeIrqSrc = st_r.rawIn; // R19
  assign spiMisoIn = st_r.spiMiso; // R18
  assign spiMosiIn = st_r.spiMosi;
  assign progDataIn = st_r.spiMosi; // R18
  assign spiSckIn = st_r.spiSck;
  assign spiSlaveSelIn = st_r.spiSs;
  // analog access is a pad-level wire outside this digital block: R15 has no logic here
  // ****************************************
  // checks
  // ****************************************
  // a write lands on the edge where the idle slave first sees it, not on the answer edge
  logic hitPinWrite;
  assign hitPinWrite = avsWrite & avsWaitrequest & avsByteenable[0] & (avsAddress == `PPO_OFS_PIN) & (toggleOvrEn == 8'h00);
  sequence s_pu_write;
    hitPinWrite;
  endsequence
  chk_pin_toggle: assert property (@(posedge clock) disable iff (rst) s_pu_write |=> (st_r.outBits == ($past(st_r.outBits) ^ $past(avsWritedata[7:0])))) else $error("pin write did not toggle"); // R21
  chk_reset_pullup: assert property (@(posedge clock) rst |=> (pullupOn == 8'h00) && (padOe == 8'h00)) else $error("pullup on in reset"); // R4
  chk_clamp_input: assert property (@(posedge clock) disable iff (rst) (sleepClamp && !pcie && extIrqEnable == 8'h00) |=> (rawDigitalIn == 8'h00)) else $error("clamped input not low"); // R1
  chk_dir_follow: assert property (@(posedge clock) disable iff (rst) (!spe) |=> (padOe == $past(st_r.dirBits))) else $error("driver not from direction"); // R7
  chk_spi_force_in: assert property (@(posedge clock) disable iff (rst) (spe && !mstr) |=> (padOe[2:0] == 3'b000)) else $error("slave pins not inputs"); // R8
  chk_cmp_value: assert property (@(posedge clock) disable iff (rst) st_r.alt[`PPO_ALT_TIMER1_CMP_B_OUT] |=> (padOut[6] == $past(timer1CmpBOut))) else $error("compare value lost"); // R10
  chk_toggle_ovr: assert property (@(posedge clock) disable iff (rst) (toggleOvrEn[0] && !avsWrite) |=> (st_r.outBits[0] != $past(st_r.outBits[0]))) else $error("toggle override ignored"); // R11
  chk_pud_pullup: assert property (@(posedge clock) disable iff (rst) (global_pullup_disable && !spe && st_r.inResetN) |=> (pullupOn == 8'h00)) else $error("pullup with disable set"); // R5
  chk_wait_one: assert property (@(posedge clock) disable iff (rst) (avsRead && avsWaitrequest) |=> !avsWaitrequest) else $error("bus answer late");
endmodule // ppo_port_b

/* File: ppo_defs.svh */
// ppo_defs.svh: register offsets, field positions and reset values for the port B pin override block
// assumes: included by the port B module and the bench of this block
`ifndef PPO_DEFS_SVH
`define PPO_DEFS_SVH
// ****************************************
// register word offsets (byte address / 4)
// ****************************************
`define PPO_OFS_OUT 4'h0
`define PPO_OFS_DIR 4'h1
`define PPO_OFS_PIN 4'h2
`define PPO_OFS_CTRL 4'h3
`define PPO_OFS_PAD 4'h4
`define PPO_OFS_ALT 4'h5
// ****************************************
// field positions and reset values
// ****************************************
`define PPO_CTRL_PUD 0
`define PPO_CTRL_SLEEP 1
`define PPO_ALT_SPE 0
`define PPO_ALT_MSTR 1
`define PPO_ALT_PCIE 2
`define PPO_ALT_TIMER0_CMP_A_OUT 3
`define PPO_ALT_TIMER1_CMP_A_OUT 4
`define PPO_ALT_TIMER1_CMP_B_OUT 5
`define PPO_ALT_TIMER1_CMP_C_OUT 6
`define PPO_ALT_TIMER2_CMP_A_OUT 7
`define PPO_RST_BYTE 8'h00
`define PPO_BAD_READ 32'hDEAD_0000
`endif

/* File: ppo_pkg.sv */
// ppo_pkg.sv: shared types of the port B pin override block
// assumes: nothing beyond a SystemVerilog compiler
package ppo_pkg;
  typedef enum logic [1:0] {
    PPO_BUS_IDLE = 2'b01,
    PPO_BUS_ACK = 2'b10
  } ppo_bus_e;
  typedef struct packed {
    logic puOvrEn;
    logic puOvrVal;
    logic dirOvrEn;
    logic dirOvrVal;
    logic valOvrEn;
    logic valOvrVal;
    logic inEnOvrEn;
    logic inEnOvrVal;
  } ppo_ovr_s;
endpackage : ppo_pkg

/* File: ppo_pin_cell.sv */
// ppo_pin_cell.sv: combinational pad control for one pin, applying the alternate-function overrides
// assumes: override inputs come from the owning peripheral; pad input taken as synchronous
`timescale 1ns/1ns
module ppo_pin_cell (
  input wire logic dirBit,
  input wire logic outBit,
  input wire logic globalPullupDisable,
  input wire logic sleepClamp,
  input wire logic inResetN,
  input wire ppo_pkg::ppo_ovr_s ovr,
  input wire logic padIn,
  output logic padOe,
  output logic padOut,
  output logic pullupOn,
  output logic rawDigitalIn
);
  logic inputEn;
  always_comb begin
    // pull-ups are off while reset holds the pin, whatever software set
    if (!inResetN) begin
      pullupOn = 1'b0; // R4
    end else if (ovr.puOvrEn) begin
      pullupOn = ovr.puOvrVal; // R5 R6
    end else begin
      pullupOn = ({dirBit, outBit, globalPullupDisable} == 3'b010); // R5 R20
    end
    padOe = ovr.dirOvrEn ? ovr.dirOvrVal : dirBit; // R7 R8 R20
    padOut = ovr.valOvrEn ? ovr.valOvrVal : outBit; // R9 R10
    // an enabled input override (e.g. pin-change source) keeps the input alive in sleep
    inputEn = ovr.inEnOvrEn ? ovr.inEnOvrVal : !sleepClamp; // R1 R2 R12 R13
    rawDigitalIn = inputEn & padIn; // R1 R14
  end
endmodule // ppo_pin_cell

/* File: ppo_periph_model.sv */
// ppo_periph_model.sv: stand-in for the timers, SPI, interrupt logic and programming port beside port B
// assumes: bench sets the cmd inputs by non-blocking assignment at the rising clock edge
`timescale 1ns/1ns
module ppo_periph_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] cmdCmp,
  input wire logic [2:0] cmdSpi,
  input wire logic [7:0] cmdIrq,
  input wire logic [7:0] cmdTgl,
  input wire logic cmdProg,
  input wire logic [7:0] rawDigitalIn,
  output logic [4:0] cmpOut,
  output logic [2:0] spiOut,
  output logic [7:0] extIrqEnable,
  output logic [7:0] toggleOvrEn,
  output logic progEnable,
  output logic [7:0] syncIn
);
  typedef struct packed {
    logic [4:0] cmp;
    logic [2:0] spi;
    logic [7:0] irq;
    logic [7:0] tgl;
    logic prog;
    logic [15:0] sync;
  } ppo_model_s;
  ppo_model_s model_r;
  ppo_model_s model_nxt;
  always_comb begin
    model_nxt = '{cmdCmp, cmdSpi, cmdIrq, cmdTgl, cmdProg, {model_r.sync[7:0], rawDigitalIn}};
    if (rst) begin
      model_nxt = '0;
    end
  end
  always_ff @(posedge clock) begin
    model_r <= model_nxt;
  end
  assign cmpOut = model_r.cmp;
  assign spiOut = model_r.spi;
  assign extIrqEnable = model_r.irq;
  assign toggleOvrEn = model_r.tgl;
  assign progEnable = model_r.prog;
  // raw pad input is asynchronous to us, so two flops before use
  assign syncIn = model_r.sync[15:8];
endmodule // ppo_periph_model

/* File: ppo_port_b_tb.sv */
// ppo_port_b_tb.sv: self-checking bench for the port B pin override block
// assumes: ppo_periph_model stands on the peripheral side; bench drives the pads and the Avalon bus
`timescale 1ns/1ns
`include "ppo_defs.svh"
module ppo_port_b_tb;
  logic clock, rst, avsRead, avsWrite, avsWaitrequest, cmdProg, progEnable;
  logic spiMisoIn, spiMosiIn, spiSckIn, spiSlaveSelIn, progDataIn;
  logic [3:0] avsAddress, avsByteenable;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic [7:0] padIn, padOe, padOut, pullupOn, rawDigitalIn, pinChangeIrqSrc, extIrqEnable;
  logic [7:0] toggleOvrEn, cmdIrq, cmdTgl, extLevel, syncIn;
  logic [4:0] cmdCmp, cmpOut;
  logic [2:0] cmdSpi, spiOut;
  int n_mismatch, checks;
  // pad wire: an enabled driver wins, otherwise the bench's external level
  assign padIn = (padOe & padOut) | (~padOe & extLevel);
  ppo_port_b dut (.clock(clock), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .padIn(padIn), .padOe(padOe), .padOut(padOut), .pullupOn(pullupOn),
    .rawDigitalIn(rawDigitalIn), .pinChangeIrqSrc(pinChangeIrqSrc), .extIrqEnable(extIrqEnable),
    .toggleOvrEn(toggleOvrEn), .timer0CmpAOut(cmpOut[0]), .timer1CmpAOut(cmpOut[1]),
    .timer1CmpBOut(cmpOut[2]), .timer1CmpCOut(cmpOut[3]), .timer2CmpAOut(cmpOut[4]),
    .spiMasterOut(spiOut[0]), .spiSlaveOut(spiOut[1]), .spiSckOut(spiOut[2]), .spiMisoIn(spiMisoIn),
    .spiMosiIn(spiMosiIn), .spiSckIn(spiSckIn), .spiSlaveSelIn(spiSlaveSelIn), .progDataIn(progDataIn),
    .progDataOut(1'b0), .progEnable(progEnable));
  ppo_periph_model model (.clock(clock), .rst(rst), .cmdCmp(cmdCmp), .cmdSpi(cmdSpi), .cmdIrq(cmdIrq),
    .cmdTgl(cmdTgl), .cmdProg(cmdProg), .rawDigitalIn(rawDigitalIn), .cmpOut(cmpOut), .spiOut(spiOut),
    .extIrqEnable(extIrqEnable), .toggleOvrEn(toggleOvrEn), .progEnable(progEnable), .syncIn(syncIn));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // waitrequest is read before the edge's updates land, which is the value the slave presented
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avsAddress <= a;
    avsWritedata <= {24'h00_0000, d};
    avsByteenable <= be;
    avsWrite <= w;
    avsRead <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 16);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (avsWaitrequest !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic settle();
    repeat (4) @(posedge clock);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    wr(`PPO_OFS_OUT, 8'hFF);
    settle();
    check(32'(pullupOn), 32'h0000_00FF);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    check(32'(pullupOn), 32'h0000_0000);
    rst <= 1'b0;
    bus(1'b0, `PPO_OFS_OUT, 8'h00, 4'h1);
    check(rd, 32'h0000_0000);
  endtask
  task automatic t_default();
    wr(`PPO_OFS_DIR, 8'h0C);
    wr(`PPO_OFS_OUT, 8'h0A);
    settle();
    check(32'(padOe), 32'h0000_000C);
    check(32'(pullupOn), 32'h0000_0002);
    check(32'(padOut & padOe), 32'h0000_0008);
    wr(`PPO_OFS_CTRL, 8'h01);
    settle();
    check(32'(pullupOn), 32'h0000_0000);
    wr(`PPO_OFS_CTRL, 8'h00);
    bus(1'b1, `PPO_OFS_OUT, 8'hFF, 4'h0);
    wr(`PPO_OFS_PIN, 8'h05);
    bus(1'b0, `PPO_OFS_OUT, 8'h00, 4'h1);
    check(rd, 32'h0000_000F);
    bus(1'b0, 4'hF, 8'h00, 4'h1);
    check(rd, `PPO_BAD_READ);
  endtask
  // bit 0 is held for one cycle and bit 1 for two, so only a per-cycle inversion gives 0E
  task automatic t_toggle();
    @(posedge clock);
    cmdTgl <= 8'h03;
    @(posedge clock);
    cmdTgl <= 8'h02;
    @(posedge clock);
    cmdTgl <= 8'h00;
    bus(1'b0, `PPO_OFS_OUT, 8'h00, 4'h1);
    check(rd, 32'h0000_000E);
  endtask
  task automatic t_clamp();
    wr(`PPO_OFS_DIR, 8'h00);
    extLevel <= 8'hFF;
    cmdIrq <= 8'h10;
    wr(`PPO_OFS_CTRL, 8'h02);
    settle();
    check(32'(rawDigitalIn), 32'h0000_0010);
    check(32'(pinChangeIrqSrc), 32'h0000_0010);
    wr(`PPO_OFS_ALT, 8'h04);
    settle();
    check(32'(rawDigitalIn), 32'h0000_00FF);
    wr(`PPO_OFS_ALT, 8'h00);
    wr(`PPO_OFS_CTRL, 8'h00);
    settle();
    check(32'(pinChangeIrqSrc), 32'h0000_00FF);
    check(32'(syncIn), 32'h0000_00FF);
    cmdIrq <= 8'h00;
  endtask
  task automatic t_timers();
    logic [4:0] pats [2];
    pats = '{5'h15, 5'h0A};
    wr(`PPO_OFS_DIR, 8'hF0);
    wr(`PPO_OFS_OUT, 8'hF0);
    wr(`PPO_OFS_ALT, 8'hB8);
    for (int i = 0; i < 2; i++) begin
      cmdCmp <= pats[i];
      settle();
      check(32'(padOut[7:4]), 32'({pats[i][0], pats[i][2], pats[i][1], pats[i][4]}));
    end
    wr(`PPO_OFS_ALT, 8'h00);
  endtask
  task automatic t_spi();
    extLevel <= 8'h0E;
    cmdSpi <= 3'b000;
    wr(`PPO_OFS_DIR, 8'h0F);
    wr(`PPO_OFS_OUT, 8'h0F);
    wr(`PPO_OFS_ALT, 8'h03);
    settle();
    check(32'(padOe[3:0]), 32'h0000_0007);
    check(32'(padOut[2:1]), 32'h0000_0000);
    check(32'(spiMisoIn), 32'h0000_0001);
    wr(`PPO_OFS_ALT, 8'h01);
    settle();
    check(32'(padOe[3:0]), 32'h0000_0008);
    check(32'(padOut[3]), 32'h0000_0000);
    check(32'({spiMosiIn, spiSckIn, spiSlaveSelIn}), 32'h0000_0006);
    check(32'(pullupOn[2:0]), 32'h0000_0007);
    cmdProg <= 1'b1;
    wr(`PPO_OFS_ALT, 8'h00);
    settle();
    check(32'(progDataIn), 32'h0000_0001);
    cmdProg <= 1'b0;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    {avsRead, avsWrite, cmdProg} = 3'b000;
    avsAddress = 4'h0;
    avsByteenable = 4'h0;
    avsWritedata = 32'h0000_0000;
    {cmdIrq, cmdTgl, extLevel} = 24'h00_0000;
    cmdCmp = 5'h00;
    cmdSpi = 3'h0;
    repeat (8) @(posedge clock);
    check(32'(padOe), 32'h0000_0000);
    rst <= 1'b0;
    t_reset();
    t_default();
    t_toggle();
    t_clamp();
    t_timers();
    t_spi();
    print_verdict();
  end
endmodule // ppo_port_b_tb
